//--- design/rcaf_pkg.sv
// reset cause and time-out package: offsets, fields, reset values, counts
// assumes a 100 MHz system clock; register indices are word indices on the bus
package rcaf_pkg;

  // ----------------------------------------------------------------
  // clock and time-out figures
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PWRT_TIME_MS = 64;
  localparam int PWRT_CYCLES = PWRT_TIME_MS * 1000 * CLK_MHZ;
  localparam int LFOSC_KHZ = 31;
  localparam int OST_PERIODS = 1024;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PCL = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_RCF = 8'h8e;
  localparam logic [7:0] IDX_CFG = 8'ha0;
  localparam logic [7:0] IDX_IRQ_STAT = 8'ha1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'ha2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int RCF_ULTRA_LOW_POWER_WAKE_EN_BIT = 5;
  localparam int RCF_SW_BROWNOUT_EN_BIT = 4;
  localparam int RCF_POR_BIT = 1;
  localparam int RCF_BOR_BIT = 0;
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_PWRTD_BIT = 3;
  localparam int CFG_BORSEL_LSB = 4;
  localparam int CFG_T1_BIT = 6;

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_POR_RST = 8'h18;
  localparam logic [7:0] STAT_WMASK = 8'he7;
  localparam logic [7:0] RCF_POR_RST = 8'h10;
  localparam logic [7:0] RCF_WMASK = 8'h33;
  localparam logic [7:0] CFG_RST = 8'h3c;
  localparam logic [7:0] PCL_RST = 8'h00;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OSC_LP = 3'h0;
  localparam logic [2:0] OSC_XT = 3'h1;
  localparam logic [2:0] OSC_HS = 3'h2;
  localparam logic [1:0] BOR_OFF = 2'h0;
  localparam logic [1:0] BOR_SW = 2'h1;
  localparam logic [1:0] BOR_NOSLP = 2'h2;
  localparam logic [1:0] BOR_ON = 2'h3;

  localparam int IRQ_W = 5;
  localparam int IRQ_POR = 0;
  localparam int IRQ_BOR = 1;
  localparam int IRQ_WDT = 2;
  localparam int IRQ_MCLR = 3;
  localparam int IRQ_WAKE = 4;

  typedef enum logic [2:0] {ST_HOLD, ST_PWRT, ST_OST, ST_MCLR, ST_RUN, ST_SLEEP, ST_WAKE} rcaf_state_t;
  typedef enum logic [2:0] {C_POR, C_BOR, C_MCLR, C_MCLR_SLP, C_WDT, C_WDT_WAKE, C_INT_WAKE} rcaf_cause_t;

endpackage

//--- design/rcaf_timer.sv
// down counter for the power-up and oscillator start-up delays
// assumes load is a one-cycle pulse from the same clock
`timescale 1ns/1ps
`default_nettype none

module rcaf_timer #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  // state
  output logic busy_o,
  output logic done_o
);

  logic [W-1:0] count_r;

  // done comes count_i edges after load; zero gives one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      count_r <= count_i;
      busy_o <= (count_i > W'(1));
      done_o <= (count_i <= W'(1));
    end else if (busy_o) begin
      count_r <= count_r - W'(1);
      busy_o <= (count_r > W'(2));
      done_o <= (count_r == W'(2));
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule // rcaf_timer

`default_nettype wire

//--- design/rcaf_top.sv
// reset cause recording and reset time-out selection
// assumes reset pins arrive asynchronously; sleep_enter_i comes from the core clock
//
// How it works
// - reset cause register at index 8Eh
// - brownout flag cleared by brownout, software sets
// - brownout flag unspecified when brownout disabled
// - power-on flag cleared only by power-on
// - crystal modes add 1024-period start-up wait
// - other modes: power-up timer only, or none
// - power-on: flags cleared, timeout/powerdown set
// - cause register fields and reset values
// - core status reset values per cause
// - resets load defaults; wake keeps, pc+1
// - power-up timer holds reset 64 ms
// - power-up timer disable bit active high
`timescale 1ns/1ps
`default_nettype none

module rcaf_top
  import rcaf_pkg::*;
#(
  parameter int PWRT_CNT = PWRT_CYCLES,
  parameter int OST_CNT = OST_PERIODS
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // reset and wake sources (asynchronous)
  input wire logic brownout_det_i,
  input wire logic mclr_n_i,
  input wire logic wdt_timeout_i,
  input wire logic int_wake_i,
  // core side
  input wire logic sleep_enter_i,
  output logic core_reset_o,
  output logic wake_stall_o,
  output logic brownout_en_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o,
  output logic [7:0] pc_low_byte_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rcaf_state_t state_r, state_nxt;
  rcaf_cause_t cause_r, cause_nxt;
  logic [7:0] stat_r;
  logic [7:0] rcf_r;
  logic [7:0] cfg_r;
  logic [7:0] pcl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic ack_r;
  logic [31:0] dat_r;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_cnt;
  logic tmr_done;
  logic release_now;
  logic in_reset;
  logic pwr_cause;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bor_s_r;
  logic [1:0] mclr_s_r;
  logic [2:0] wdt_s_r;
  logic [2:0] wake_s_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bor_s_r <= 2'h0;
      mclr_s_r <= 2'h3;
      wdt_s_r <= 3'h0;
      wake_s_r <= 3'h0;
    end else begin
      bor_s_r <= {bor_s_r[0], brownout_det_i};
      mclr_s_r <= {mclr_s_r[0], mclr_n_i};
      wdt_s_r <= {wdt_s_r[1:0], wdt_timeout_i};
      wake_s_r <= {wake_s_r[1:0], int_wake_i};
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [2:0] osc_mode;
  logic [1:0] brownout_mode_sel;
  logic powerup_timer_disable;
  logic timer1_osc_input;
  logic bor_en;
  logic bor_evt;
  logic mclr_act;
  logic wdt_evt;
  logic wake_evt;

  assign osc_mode = cfg_r[CFG_OSC_LSB +: 3];
  assign brownout_mode_sel = cfg_r[CFG_BORSEL_LSB +: 2];
  assign powerup_timer_disable = cfg_r[CFG_PWRTD_BIT];
  assign timer1_osc_input = cfg_r[CFG_T1_BIT];

  // crystal or resonator driven, so start-up counting applies
  function automatic logic xtal_mode(input logic [2:0] osc, input logic t1);
    xtal_mode = ((osc == OSC_LP) && !t1) || (osc == OSC_XT) || (osc == OSC_HS);
  endfunction

  // brownout detector gating by mode select
  always_comb begin
    unique case (brownout_mode_sel)
      BOR_OFF: bor_en = 1'b0;
      BOR_SW: bor_en = rcf_r[RCF_SW_BROWNOUT_EN_BIT];
      BOR_NOSLP: bor_en = (state_r != ST_SLEEP);
      BOR_ON: bor_en = 1'b1;
    endcase
  end

  assign bor_evt = bor_en && bor_s_r[1];
  assign mclr_act = !mclr_s_r[1];
  assign wdt_evt = wdt_s_r[1] && !wdt_s_r[2];
  assign wake_evt = wake_s_r[1] && !wake_s_r[2];
  assign in_reset = (state_r == ST_HOLD) || (state_r == ST_PWRT) || (state_r == ST_OST) || (state_r == ST_MCLR);
  assign pwr_cause = (cause_r == C_POR) || (cause_r == C_BOR);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    tmr_load = 1'b0;
    tmr_cnt = '0;
    release_now = 1'b0;
    if (bor_evt) begin
      // brownout restarts the power-up timer
      state_nxt = ST_HOLD;
      if (!(in_reset && (cause_r == C_POR)))
        cause_nxt = C_BOR;
    end else if (mclr_act && !in_reset) begin
      state_nxt = ST_HOLD;
      cause_nxt = (state_r == ST_SLEEP || state_r == ST_WAKE) ? C_MCLR_SLP : C_MCLR;
    end else if (wdt_evt && state_r == ST_RUN) begin
      state_nxt = ST_HOLD;
      cause_nxt = C_WDT;
    end else if ((wdt_evt || wake_evt) && state_r == ST_SLEEP) begin
      state_nxt = ST_WAKE;
      cause_nxt = wdt_evt ? C_WDT_WAKE : C_INT_WAKE;
      tmr_load = 1'b1;
      tmr_cnt = xtal_mode(osc_mode, timer1_osc_input) ? CNT_W'(OST_CNT) : '0;
    end else begin
      unique case (state_r)
        ST_HOLD: begin
          // power-on time-outs run even with the reset pin held
          if (!mclr_act || pwr_cause) begin
            state_nxt = ST_PWRT;
            tmr_load = 1'b1;
            tmr_cnt = (pwr_cause && !powerup_timer_disable) ? CNT_W'(PWRT_CNT) : '0;
          end
        end
        ST_PWRT: begin
          if (tmr_done) begin
            state_nxt = ST_OST;
            tmr_load = 1'b1;
            tmr_cnt = xtal_mode(osc_mode, timer1_osc_input) ? CNT_W'(OST_CNT) : '0;
          end
        end
        ST_OST: begin
          if (tmr_done)
            state_nxt = ST_MCLR;
        end
        ST_MCLR: begin
          if (!mclr_act) begin
            state_nxt = ST_RUN;
            release_now = 1'b1;
          end
        end
        ST_RUN: begin
          if (sleep_enter_i)
            state_nxt = ST_SLEEP;
        end
        ST_SLEEP: begin
          state_nxt = ST_SLEEP;
        end
        ST_WAKE: begin
          if (tmr_done) begin
            state_nxt = ST_RUN;
            release_now = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_HOLD;
      cause_r <= C_POR;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
    end
  end

  rcaf_timer #(
    .W(CNT_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .count_i(tmr_cnt),
    .busy_o(),
    .done_o(tmr_done)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic bus_req;
  logic wr_en;

  assign idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_en = bus_req && wb_we_i && wb_sel_i[0];

  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] target);
    wr_hit = en && (a == target);
  endfunction

  // ----------------------------------------------------------------
  // core status register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= STAT_POR_RST;
    end else if (release_now) begin
      unique case (cause_r)
        C_POR: stat_r <= STAT_POR_RST;
        C_BOR: stat_r <= {3'h0, 2'h3, stat_r[2:0]};
        C_WDT: stat_r <= {3'h0, 1'b0, stat_r[3:0]};
        C_MCLR: stat_r <= {3'h0, stat_r[4:0]};
        C_MCLR_SLP: stat_r <= {3'h0, 2'h2, stat_r[2:0]};
        C_WDT_WAKE: stat_r <= {stat_r[7:5], 2'h0, stat_r[2:0]};
        C_INT_WAKE: stat_r <= {stat_r[7:5], 2'h2, stat_r[2:0]};
      endcase
    end else if (state_r == ST_RUN && state_nxt == ST_SLEEP) begin
      stat_r[STAT_TO_BIT] <= 1'b1;
      stat_r[STAT_PD_BIT] <= 1'b0;
    end else if (wr_hit(wr_en, idx, IDX_STATUS)) begin
      stat_r <= (stat_r & ~STAT_WMASK) | (wb_dat_i[7:0] & STAT_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // power-on value, brownout flag left 0
      rcf_r <= RCF_POR_RST;
    end else if (release_now) begin
      unique case (cause_r)
        C_POR: begin
          rcf_r <= RCF_POR_RST;
        end
        C_BOR: begin
          rcf_r <= {2'h0, 1'b0, 1'b1, 2'h0, rcf_r[RCF_POR_BIT], 1'b0};
        end
        C_WDT, C_MCLR, C_MCLR_SLP: begin
          // other resets keep all but wake enable
          rcf_r <= rcf_r & ~(8'h01 << RCF_ULTRA_LOW_POWER_WAKE_EN_BIT);
        end
        C_WDT_WAKE, C_INT_WAKE: begin
          rcf_r <= rcf_r;
        end
      endcase
    end else if (wr_hit(wr_en, idx, IDX_RCF)) begin
      rcf_r <= (rcf_r & ~RCF_WMASK) | (wb_dat_i[7:0] & RCF_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // program counter low byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcl_r <= PCL_RST;
    end else if (release_now) begin
      if (cause_r == C_WDT_WAKE || cause_r == C_INT_WAKE)
        pcl_r <= pcl_r + 8'h01;
      else
        pcl_r <= PCL_RST;
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cfg_r <= CFG_RST;
    else if (wr_hit(wr_en, idx, IDX_CFG))
      cfg_r <= {1'b0, wb_dat_i[6:0]};
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    if (release_now) begin
      unique case (cause_r)
        C_POR: irq_set[IRQ_POR] = 1'b1;
        C_BOR: irq_set[IRQ_BOR] = 1'b1;
        C_WDT: irq_set[IRQ_WDT] = 1'b1;
        C_MCLR, C_MCLR_SLP: irq_set[IRQ_MCLR] = 1'b1;
        C_WDT_WAKE, C_INT_WAKE: irq_set[IRQ_WAKE] = 1'b1;
      endcase
    end
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_stat_r <= '0;
    else if (wr_hit(wr_en, idx, IDX_IRQ_STAT))
      irq_stat_r <= (irq_stat_r & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
    else
      irq_stat_r <= irq_stat_r | irq_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_mask_r <= '0;
    else if (wr_hit(wr_en, idx, IDX_IRQ_MASK))
      irq_mask_r <= wb_dat_i[IRQ_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_r & irq_mask_r);
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  always_comb begin
    dat_r = '0;
    unique case (idx)
      IDX_PCL: dat_r[7:0] = pcl_r;
      IDX_STATUS: dat_r[7:0] = stat_r;
      IDX_RCF: dat_r[7:0] = rcf_r & RCF_WMASK;
      IDX_CFG: dat_r[7:0] = cfg_r;
      IDX_IRQ_STAT: dat_r[IRQ_W-1:0] = irq_stat_r;
      IDX_IRQ_MASK: dat_r[IRQ_W-1:0] = irq_mask_r;
      default: dat_r = '0;
    endcase
  end

  // one wait state; unmapped reads zero, writes dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= dat_r;
    end
  end

  assign wb_ack_o = ack_r;

  // ----------------------------------------------------------------
  // core side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      wake_stall_o <= 1'b0;
      brownout_en_o <= 1'b0;
    end else begin
      core_reset_o <= (state_nxt == ST_HOLD) || (state_nxt == ST_PWRT) || (state_nxt == ST_OST) ||
                      (state_nxt == ST_MCLR);
      wake_stall_o <= (state_nxt == ST_WAKE);
      brownout_en_o <= bor_en;
    end
  end

  assign timeout_flag_n_o = stat_r[STAT_TO_BIT];
  assign powerdown_flag_n_o = stat_r[STAT_PD_BIT];
  assign pc_low_byte_o = pcl_r;

endmodule // rcaf_top

`default_nettype wire

//--- verification/rcaf_sva.sv
// port checker for the reset cause and time-out block
// assumes one clock clk_i with synchronous reset rst_i; bound into rcaf_top
`timescale 1ns/1ps
`default_nettype none

module rcaf_sva
  import rcaf_pkg::*;
#(
  parameter int PWRT_CNT = PWRT_CYCLES,
  parameter int OST_CNT = OST_PERIODS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [9:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sources and core side
  input wire logic brownout_det_i,
  input wire logic mclr_n_i,
  input wire logic sleep_enter_i,
  input wire logic core_reset_o,
  input wire logic wake_stall_o,
  input wire logic brownout_en_o,
  input wire logic timeout_flag_n_o,
  input wire logic powerdown_flag_n_o,
  input wire logic [7:0] pc_low_byte_o
);
  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic take;
  logic [7:0] idx;
  logic mapped;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[9:2];
  assign mapped = idx inside {IDX_PCL, IDX_STATUS, IDX_RCF, IDX_CFG, IDX_IRQ_STAT, IDX_IRQ_MASK};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ack_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle after request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (take && !wb_we_i && !mapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_mirror: assert property (take && !wb_we_i && idx == IDX_STATUS
    |=> wb_dat_o[4] == $past(timeout_flag_n_o) && wb_dat_o[3] == $past(powerdown_flag_n_o))
    else $error("status read disagrees with flag outputs");
  a_mclr_holds: assert property (!mclr_n_i [*6] |-> core_reset_o)
    else $error("core not held while external reset low");
  a_bor_holds: assert property ((brownout_det_i && brownout_en_o) [*6] |-> core_reset_o)
    else $error("core not held during brownout");
  a_pcl_cleared: assert property ($fell(core_reset_o) |-> pc_low_byte_o == PCL_RST)
    else $error("pc low byte not cleared by reset");
  a_wake_pd: assert property (wake_stall_o |-> !powerdown_flag_n_o)
    else $error("powerdown flag set while waking");
  a_sleep_flags: assert property (sleep_enter_i && !core_reset_o && !wake_stall_o
    |-> ##[1:3] (timeout_flag_n_o && !powerdown_flag_n_o))
    else $error("sleep entry flags wrong");
endmodule // rcaf_sva

bind rcaf_top rcaf_sva #(.PWRT_CNT(PWRT_CNT), .OST_CNT(OST_CNT)) i_rcaf_sva (
  .clk_i, .rst_i, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .brownout_det_i,
  .mclr_n_i, .sleep_enter_i, .core_reset_o, .wake_stall_o, .brownout_en_o, .timeout_flag_n_o,
  .powerdown_flag_n_o, .pc_low_byte_o
);

`default_nettype wire

//--- verification/rcaf_top_tb.sv
// self-checking bench for rcaf_top: registers, reset causes, time-outs, sleep, interrupt
// assumes the port checker is bound in; counts shortened to PW and OS
`timescale 1ns/1ps
`default_nettype none

module rcaf_top_tb
  import rcaf_pkg::*;
;
  localparam int PW = 20;
  localparam int OS = 8;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clk_i;
  logic rst_i;
  logic [9:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [3:0] wb_sel_i;
  logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, xt;
  logic brownout_det_i, mclr_n_i, wdt_timeout_i, int_wake_i, sleep_enter_i;
  logic core_reset_o, wake_stall_o, brownout_en_o, timeout_flag_n_o, powerdown_flag_n_o, irq_o;
  logic [7:0] pc_low_byte_o;
  logic [7:0] d;
  int failures, n_checks, stat, rcf, pc_low_byte, base, len, i;
  int cfgs[7] = '{8'h3c, 8'h34, 8'h39, 8'h32, 8'h30, 8'h70, 8'h3b};

  rcaf_top #(.PWRT_CNT(PW), .OST_CNT(OS)) i_rcaf_top (
    .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .brownout_det_i, .mclr_n_i, .wdt_timeout_i, .int_wake_i, .sleep_enter_i, .core_reset_o, .wake_stall_o,
    .brownout_en_o, .timeout_flag_n_o, .powerdown_flag_n_o, .pc_low_byte_o, .irq_o
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic ran_out();
    failures++;
    $display("BAD %0t wait ran out", $time);
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic single cycle, held until ack sampled high
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {8'($urandom), 16'h0, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) ran_out();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input int exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  task automatic all_chk();
    rchk(IDX_STATUS, stat);
    rchk(IDX_RCF, rcf);
    chk(pc_low_byte_o, pc_low_byte);
    chk({timeout_flag_n_o, powerdown_flag_n_o}, stat[4:3]);
  endtask

  // kinds: 0 brownout, 1 external reset, 2 watchdog, 3 interrupt wake
  task automatic event_in(input int k, input int hold);
    @(posedge clk_i);
    if (k == 0) brownout_det_i <= 1'b1;
    if (k == 1) mclr_n_i <= 1'b0;
    if (k == 2) wdt_timeout_i <= 1'b1;
    if (k == 3) int_wake_i <= 1'b1;
    repeat (hold) @(posedge clk_i);
    brownout_det_i <= 1'b0;
    mclr_n_i <= 1'b1;
    wdt_timeout_i <= 1'b0;
    int_wake_i <= 1'b0;
  endtask

  // cycles until core reset (w=0) or wake stall (w=1) has risen and fallen
  task automatic wait_done(input bit w, output int n);
    bit up;
    up = 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if ((w ? wake_stall_o : core_reset_o) === 1'b1) up = 1'b1;
    end while (!(up && (w ? wake_stall_o : core_reset_o) === 1'b0) && n < 3000);
    if (n >= 3000) ran_out();
  endtask

  task automatic go_sleep();
    @(posedge clk_i);
    sleep_enter_i <= 1'b1;
    @(posedge clk_i);
    sleep_enter_i <= 1'b0;
    stat = stat & 8'he7 | 8'h10;
    repeat (3) @(posedge clk_i);
  endtask

  // flag, pcl and cause register model per event
  task automatic model(input int k, input bit slp);
    if (k == 0) begin
      stat = stat & 8'h07 | 8'h18;
      rcf = rcf & 8'h02 | 8'h10;
    end else if (k == 1 || !slp) begin
      stat = slp ? stat & 8'h07 | 8'h10 : stat & (k == 1 ? 8'h1f : 8'h0f);
      rcf = rcf & 8'h13;
    end else begin
      stat = stat & 8'he7 | (k == 3 ? 8'h10 : 8'h00);
    end
    pc_low_byte = (k < 2 || !slp) ? 0 : pc_low_byte + 1;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h4f50));
    {wb_cyc_i, wb_stb_i, wb_we_i, brownout_det_i, wdt_timeout_i, int_wake_i, sleep_enter_i} = 7'h0;
    wb_adr_i = 10'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h1;
    mclr_n_i = 1'b1;
    rst_i = 1'b1;
    failures = 0;
    n_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_done(1'b0, len);
    stat = 8'h18;
    rcf = 8'h10;
    pc_low_byte = 0;
    all_chk();
    repeat (4) begin
      d = 8'($urandom);
      wb(1'b1, IDX_STATUS, d);
      stat = stat & 8'h18 | d & 8'he7;
      d = 8'($urandom);
      wb(1'b1, IDX_RCF, d);
      rcf = d & 8'h33;
      wb(1'b1, IDX_PCL, d);
      wb(1'b1, 8'h40 + 8'($urandom_range(0, 63)), d);
      rchk(8'h40 + 8'($urandom_range(0, 63)), 0);
      all_chk();
    end
    wb_sel_i <= 4'he;
    wb(1'b1, IDX_RCF, 8'h00);
    rchk(IDX_RCF, rcf);
    wb_sel_i <= 4'h1;
    wb(1'b1, IDX_RCF, 8'h13);
    rcf = 8'h13;
    all_chk();
    foreach (cfgs[j]) begin
      d = 8'(cfgs[j]);
      xt = d[2:0] == OSC_XT || d[2:0] == OSC_HS || (d[2:0] == OSC_LP && !d[6]);
      wb(1'b1, IDX_CFG, d);
      event_in(0, 6);
      wait_done(1'b0, len);
      model(0, 1'b0);
      if (j == 0) base = len;
      chk(len - base, (d[3] ? 1 : PW) + (xt ? OS : 1) - 2);
      all_chk();
    end
    for (i = 0; i < 2; i++) begin
      wb(1'b1, IDX_CFG, i == 0 ? 8'h3c : 8'h34);
      event_in(1, 1);
      wait_done(1'b0, len);
      model(1, 1'b0);
      if (i == 0) base = len;
      chk(len, base);
    end
    all_chk();
    event_in(2, 1);
    wait_done(1'b0, len);
    model(2, 1'b0);
    all_chk();
    for (i = 0; i < 4; i++) begin
      wb(1'b1, IDX_CFG, i[0] ? 8'h39 : 8'h3c);
      go_sleep();
      all_chk();
      event_in(i < 2 ? 3 : 2, 1);
      wait_done(1'b1, len);
      model(i < 2 ? 3 : 2, 1'b1);
      if (!i[0]) base = len;
      else chk(len - base, OS - 1);
      all_chk();
    end
    go_sleep();
    event_in(1, 6);
    wait_done(1'b0, len);
    model(1, 1'b1);
    all_chk();
    // interrupt: mask, clear, raise by wake, unmask, clear
    d = 8'($urandom) & 8'h0f;
    wb(1'b1, IDX_IRQ_MASK, d);
    rchk(IDX_IRQ_STAT, 8'h1f);
    wb(1'b1, IDX_IRQ_STAT, 8'h1f);
    rchk(IDX_IRQ_STAT, 0);
    go_sleep();
    event_in(3, 1);
    wait_done(1'b1, len);
    model(3, 1'b1);
    rchk(IDX_IRQ_STAT, 8'h10);
    chk(irq_o, 0);
    wb(1'b1, IDX_IRQ_MASK, d | 8'h10);
    rchk(IDX_IRQ_MASK, d | 8'h10);
    chk(irq_o, 1);
    wb(1'b1, IDX_IRQ_STAT, 8'h10);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0);
    for (i = 0; i < 5; i++) begin
      wb(1'b1, IDX_CFG, 8'(8'h0c | (i == 4 ? 1 : i) << 4));
      if (i == 4) wb(1'b1, IDX_RCF, 8'h03);
      repeat (2) @(posedge clk_i);
      chk(brownout_en_o, i == 1 || i == 2 || i == 3);
    end
    give_verdict();
  end
endmodule // rcaf_top_tb

`default_nettype wire
